// File: logic/sph_pkg.sv
// shared constants and types of the service and process data message handler
package sph_pkg;
	// frame geometry
	localparam logic [3:0] SDO_FRAME_LEN = 4'h8;
	localparam logic [3:0] PDO_MAX_LEN = 4'h8;
	localparam logic [15:0] EXP_MAX_LEN = 16'h0004;
	localparam logic [15:0] SEG_BYTES = 16'h0007;
	localparam int SDO_WORD_W = 68;
	localparam int FIFO_DEPTH = 4;
	localparam int PDO_COUNT = 4;
	// command bytes
	localparam logic [7:0] CMD_WR_MASK = 8'hF3;
	localparam logic [7:0] CMD_WR_BASE = 8'h23;
	localparam logic [7:0] CMD_WR_ACK = 8'h60;
	localparam logic [7:0] CMD_ERR = 8'h80;
	localparam logic [7:0] CMD_RD_REQ = 8'h40;
	localparam logic [7:0] CMD_RD_BASE = 8'h43;
	localparam logic [7:0] CMD_RD_LONG = 8'h41;
	localparam logic [7:0] CMD_SEG_REQ = 8'h60;
	localparam logic [7:0] TOGGLE_MASK = 8'h10;
	localparam int LEN_POS = 2;
	// identifier layout: function code in bits 10:7, node in bits 6:0
	localparam logic [10:0] COB_SYNC = 11'h080;
	localparam logic [3:0] FC_SDO_RX = 4'hC;
	localparam logic [3:0] FC_SDO_TX = 4'hB;
	localparam logic [3:0] FC_RPDO_FIRST = 4'h4;
	localparam logic [3:0] FC_TPDO_FIRST = 4'h3;
	localparam logic [6:0] NODE_NONE = 7'h00;
	// transmission type objects
	localparam logic [15:0] RPDO_PARAM = 16'h1400;
	localparam logic [15:0] TPDO_PARAM = 16'h1800;
	localparam logic [7:0] TT_SUB = 8'h02;
	localparam logic [7:0] TT_RESET = 8'hFF;
	localparam logic [7:0] TT_SYNC_MAX = 8'hF0;

	typedef enum logic [2:0] {
		SPH_IDLE = 3'b001,
		SPH_ACCESS = 3'b010,
		SPH_SEND = 3'b100
	} sph_state_t;
endpackage

// File: logic/sph_stream_if.sv
// valid/ready word stream between the handler and its request queue
`timescale 1ns/1ps
interface sph_stream_if #(parameter int W = 68);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport source(output valid, output data, input ready);
	modport sink(input valid, input data, output ready);
endinterface

// File: logic/sph_fifo.sv
// small flip-flop queue with valid/ready on both sides
`timescale 1ns/1ps
module sph_fifo #(
	parameter int WIDTH = 68,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// streams
	sph_stream_if.sink in_s,
	sph_stream_if.source out_s
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_s.ready = count != FULL_COUNT;
	assign out_s.valid = count != '0;
	assign out_s.data = mem[rd_ptr];
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;

	always_ff @(posedge clock) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end

	// storage needs no reset; the count guards every read
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_s.data;
		end
	end
endmodule

// File: logic/sph_message_handler.sv
// service and process data message handler of a field bus drive node
//
// Overview of operation
// [RULE1] expedited frames carry at most four data bytes; longer values go segmented
// [RULE2] long values are delivered in successive segments of seven data bytes
// [RULE3] frame layout: command byte, 16-bit index, subindex, up to four data bytes
// [RULE4] command byte encodes message type and number of valid data bytes
// [RULE5] index and numeric data travel least significant byte first
// [RULE6] client writes with index, subindex, length in command, and value
// [RULE7] write request commands 23, 27, 2B, 2F mean four, three, two, one bytes
// [RULE8] good write answered with 60, echoing index and subindex, no data
// [RULE9] any request that cannot be evaluated gets an error answer with 80
// [RULE10] client reads with command 40 whatever the expected length
// [RULE11] read answer echoes index, subindex; 43, 47, 4B, 4F for 4..1 bytes
// [RULE12] bytes beyond the valid length are undefined and ignored
// [RULE13] objects over four bytes answer the first read with 41 and total length
// [RULE14] segment requests and answers carry a toggle, zero first, then alternating
// [RULE15] client keeps requesting segments until the last one is marked
// [RULE16] last segment answer gives the remaining byte count and ends the transfer
// [RULE17] process data frames carry one to eight mapped bytes
// [RULE18] process data goes out with no acknowledgement awaited
// [RULE19] synchronous received process data waits for the next sync message
// [RULE20] event-driven received process data takes effect at once
// [RULE21] each process data object keeps its own transmission type at subindex 2
// [RULE22] node identifier is seven bits, 1 to 127; zero means broadcast; the handler takes only sync 080 for node zero, unaddressed with zero strapped
// [RULE23] every service data frame is exactly eight bytes long
// [RULE24] toggle sits at command bit 4 and each answer echoes the request's toggle
// [RULE25] one answer per service request, requests handled in arrival order
`timescale 1ns/1ps
module sph_message_handler #(
	parameter logic [31:0] ABORT_CODE = 32'h0000_0000
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// node address strap
	input wire logic [6:0] node_id,
	output logic node_id_valid,
	// frames from the bus controller
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [10:0] rx_cob,
	input wire logic [3:0] rx_len,
	input wire logic [63:0] rx_data,
	// frames to the bus controller
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [10:0] tx_cob,
	output logic [3:0] tx_len,
	output logic [63:0] tx_data,
	// object dictionary access
	output logic od_req,
	output logic od_write,
	output logic [15:0] od_index,
	output logic [7:0] od_sub,
	output logic [15:0] od_offset,
	output logic [31:0] od_wdata,
	output logic [2:0] od_wlen,
	input wire logic od_ack,
	input wire logic od_err,
	input wire logic [55:0] od_rdata,
	input wire logic [15:0] od_rlen,
	// received process data, applied
	output logic rpdo_apply,
	output logic [1:0] rpdo_num,
	output logic [3:0] rpdo_len,
	output logic [63:0] rpdo_data,
	// process data to send
	input wire logic tpdo_valid,
	output logic tpdo_ready,
	input wire logic [1:0] tpdo_num,
	input wire logic [3:0] tpdo_len,
	input wire logic [63:0] tpdo_data
);
	function automatic logic [63:0] sph_mask(input logic [63:0] d, input logic [3:0] len);
		logic [63:0] m;
		m = '0;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < len) begin
				m[i*8 +: 8] = 8'hFF;
			end
		end
		return d & m;
	endfunction

	// node address, caught through two flops
	logic [6:0] node_meta;
	logic [6:0] node_r;
	logic node_ok;

	always_ff @(posedge clock) begin
		if (reset) begin
			node_meta <= sph_pkg::NODE_NONE;
			node_r <= sph_pkg::NODE_NONE;
		end else begin
			node_meta <= node_id;
			node_r <= node_meta;
		end
	end

	assign node_ok = node_r != sph_pkg::NODE_NONE; // RULE22
	assign node_id_valid = node_ok;

	// receive classification
	logic [3:0] rx_fc;
	logic [3:0] rx_pidx;
	logic rx_mine;
	logic rx_sync;
	logic rx_sdo;
	logic rx_rpdo;
	logic [1:0] rx_num;

	assign rx_fc = rx_cob[10:7];
	assign rx_pidx = rx_fc - sph_pkg::FC_RPDO_FIRST;
	assign rx_num = rx_pidx[2:1];
	// unaddressed until a node number is strapped
	assign rx_mine = node_ok && rx_cob[6:0] == node_r; // RULE22
	assign rx_sync = rx_valid && rx_cob == sph_pkg::COB_SYNC;
	assign rx_sdo = rx_valid && rx_mine && rx_fc == sph_pkg::FC_SDO_RX;
	assign rx_rpdo = rx_valid && rx_mine && rx_fc >= sph_pkg::FC_RPDO_FIRST
		&& !rx_pidx[3] && !rx_pidx[0];

	// service requests queue up; only they can be stalled
	sph_stream_if #(.W(sph_pkg::SDO_WORD_W)) rx_q ();
	sph_stream_if #(.W(sph_pkg::SDO_WORD_W)) sdo_q ();

	sph_fifo #(.WIDTH(sph_pkg::SDO_WORD_W), .DEPTH(sph_pkg::FIFO_DEPTH)) sph_fifo_i (
		.clock(clock),
		.reset(reset),
		.in_s(rx_q),
		.out_s(sdo_q)
	);

	assign rx_q.valid = rx_sdo;
	assign rx_q.data = {rx_len, rx_data};
	assign rx_ready = rx_sdo ? rx_q.ready : 1'b1;

	// transmission types
	logic [7:0] tt_rx [sph_pkg::PDO_COUNT];
	logic [7:0] tt_tx [sph_pkg::PDO_COUNT];

	// queued request fields
	sph_pkg::sph_state_t state;
	logic [3:0] f_len;
	logic [7:0] f_cmd;
	logic [15:0] f_idx;
	logic [7:0] f_sub;
	logic [31:0] f_val;
	logic f_is_rx;
	logic f_tt;
	logic f_wr;
	logic f_rd;
	logic f_seg;
	logic f_tog;
	logic [7:0] f_tt_val;
	logic tt_wr;

	assign f_len = sdo_q.data[67:64]; // RULE23
	assign f_cmd = sdo_q.data[7:0]; // RULE3
	assign f_idx = sdo_q.data[23:8]; // RULE5
	assign f_sub = sdo_q.data[31:24];
	assign f_val = sdo_q.data[63:32];
	assign f_is_rx = f_idx[15:2] == sph_pkg::RPDO_PARAM[15:2];
	assign f_tt = f_sub == sph_pkg::TT_SUB
		&& (f_is_rx || f_idx[15:2] == sph_pkg::TPDO_PARAM[15:2]); // RULE21
	assign f_wr = (f_cmd & sph_pkg::CMD_WR_MASK) == sph_pkg::CMD_WR_BASE; // RULE7
	assign f_rd = f_cmd == sph_pkg::CMD_RD_REQ; // RULE10
	assign f_seg = (f_cmd & ~sph_pkg::TOGGLE_MASK) == sph_pkg::CMD_SEG_REQ;
	assign f_tog = |(f_cmd & sph_pkg::TOGGLE_MASK); // RULE24
	assign f_tt_val = f_is_rx ? tt_rx[f_idx[1:0]] : tt_tx[f_idx[1:0]];
	assign sdo_q.ready = state == sph_pkg::SPH_IDLE; // RULE25
	assign tt_wr = sdo_q.valid && sdo_q.ready && f_len == sph_pkg::SDO_FRAME_LEN
		&& f_wr && f_tt;

	always_ff @(posedge clock) begin
		if (reset) begin
			for (int i = 0; i < sph_pkg::PDO_COUNT; i++) begin
				tt_rx[i] <= sph_pkg::TT_RESET;
				tt_tx[i] <= sph_pkg::TT_RESET;
			end
		end else if (tt_wr) begin
			if (f_is_rx) begin
				tt_rx[f_idx[1:0]] <= f_val[7:0]; // RULE21
			end else begin
				tt_tx[f_idx[1:0]] <= f_val[7:0]; // RULE21
			end
		end
	end

	// received process data
	logic [63:0] rp_data [sph_pkg::PDO_COUNT];
	logic [3:0] rp_len [sph_pkg::PDO_COUNT];
	logic [3:0] rp_pend;
	logic [3:0] rp_due;
	logic rp_take;
	logic rp_sync_type;
	logic [3:0] rp_bit;
	logic ap_hit;
	logic [1:0] ap_sel;
	logic [3:0] ap_clear;

	assign rp_take = rx_rpdo && rx_len != 4'h0 && rx_len <= sph_pkg::PDO_MAX_LEN; // RULE17
	assign rp_sync_type = tt_rx[rx_num] <= sph_pkg::TT_SYNC_MAX;
	assign rp_bit = rp_take ? 4'h1 << rx_num : 4'h0;

	always_comb begin
		ap_hit = 1'b0;
		ap_sel = 2'h0;
		for (int i = sph_pkg::PDO_COUNT - 1; i >= 0; i--) begin
			if (rp_due[i]) begin
				ap_hit = 1'b1;
				ap_sel = 2'(i);
			end
		end
	end

	assign ap_clear = ap_hit ? 4'h1 << ap_sel : 4'h0;

	// a new arrival sets its flag after the clear, so it is never lost
	always_ff @(posedge clock) begin
		if (reset) begin
			rp_pend <= 4'h0;
			rp_due <= 4'h0;
		end else begin
			rp_pend <= (rx_sync ? 4'h0 : rp_pend) | (rp_sync_type ? rp_bit : 4'h0); // RULE19
			rp_due <= (rp_due & ~ap_clear) | (rx_sync ? rp_pend : 4'h0)
				| (rp_sync_type ? 4'h0 : rp_bit); // RULE20
		end
	end

	always_ff @(posedge clock) begin
		if (rp_take) begin
			rp_data[rx_num] <= sph_mask(rx_data, rx_len); // RULE12
			rp_len[rx_num] <= rx_len;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			rpdo_apply <= 1'b0;
			rpdo_num <= 2'h0;
			rpdo_len <= 4'h0;
			rpdo_data <= 64'h0;
		end else begin
			rpdo_apply <= ap_hit;
			if (ap_hit) begin
				rpdo_num <= ap_sel;
				rpdo_len <= rp_len[ap_sel];
				rpdo_data <= rp_data[ap_sel];
			end
		end
	end

	// process data to send, held one deep
	logic tp_full;
	logic tp_armed;
	logic [1:0] tp_num;
	logic [3:0] tp_len;
	logic [63:0] tp_data;
	logic tp_take;
	logic tp_go;
	logic slot_free;
	logic tp_sent;
	logic sdo_sent;

	assign tpdo_ready = !tp_full;
	assign tp_take = tpdo_valid && !tp_full;
	assign tp_go = tp_full && tp_armed;
	assign slot_free = !tx_valid || tx_ready;
	// process data goes first: it is the time-critical traffic
	assign tp_sent = slot_free && tp_go;
	assign sdo_sent = slot_free && !tp_go && state == sph_pkg::SPH_SEND;

	always_ff @(posedge clock) begin
		if (reset) begin
			tp_full <= 1'b0;
			tp_armed <= 1'b0;
		end else if (tp_take) begin
			tp_full <= tpdo_len != 4'h0 && tpdo_len <= sph_pkg::PDO_MAX_LEN; // RULE17
			tp_armed <= tt_tx[tpdo_num] > sph_pkg::TT_SYNC_MAX; // RULE21
		end else begin
			if (rx_sync) begin
				tp_armed <= 1'b1;
			end
			if (tp_sent) begin
				tp_full <= 1'b0; // RULE18
			end
		end
	end

	always_ff @(posedge clock) begin
		if (tp_take) begin
			tp_num <= tpdo_num;
			tp_len <= tpdo_len;
			tp_data <= sph_mask(tpdo_data, tpdo_len); // RULE12
		end
	end

	// answer being built
	logic [7:0] resp_cmd;
	logic [55:0] resp_data;

	always_ff @(posedge clock) begin
		if (reset) begin
			tx_valid <= 1'b0;
			tx_cob <= 11'h000;
			tx_len <= 4'h0;
			tx_data <= 64'h0;
		end else if (tp_sent) begin
			tx_valid <= 1'b1;
			tx_cob <= {sph_pkg::FC_TPDO_FIRST + {1'b0, tp_num, 1'b0}, node_r};
			tx_len <= tp_len; // RULE17
			tx_data <= tp_data;
		end else if (sdo_sent) begin
			tx_valid <= 1'b1;
			tx_cob <= {sph_pkg::FC_SDO_TX, node_r};
			tx_len <= sph_pkg::SDO_FRAME_LEN; // RULE23
			tx_data <= {resp_data, resp_cmd}; // RULE3
		end else if (tx_ready) begin
			tx_valid <= 1'b0;
		end
	end

	// service data engine
	logic acc_seg;
	logic seg_active;
	logic seg_tog;
	logic [15:0] seg_idx;
	logic [7:0] seg_sub;
	logic [15:0] seg_off;
	logic [15:0] seg_total;
	logic [15:0] seg_rem;
	logic seg_last;
	logic [2:0] seg_n;
	logic [7:0] seg_cmd;
	logic [1:0] rd_code;

	assign seg_rem = seg_total - seg_off;
	assign seg_last = seg_rem <= sph_pkg::SEG_BYTES; // RULE16
	assign seg_n = seg_last ? seg_rem[2:0] : sph_pkg::SEG_BYTES[2:0]; // RULE2
	assign seg_cmd = (seg_tog ? sph_pkg::TOGGLE_MASK : 8'h00)
		| {4'h0, sph_pkg::SEG_BYTES[2:0] - seg_n, seg_last}; // RULE24
	assign rd_code = 2'(sph_pkg::EXP_MAX_LEN - od_rlen);

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= sph_pkg::SPH_IDLE;
			od_req <= 1'b0;
			od_write <= 1'b0;
			od_index <= 16'h0000;
			od_sub <= 8'h00;
			od_offset <= 16'h0000;
			od_wdata <= 32'h0000_0000;
			od_wlen <= 3'h0;
			acc_seg <= 1'b0;
			seg_active <= 1'b0;
			seg_tog <= 1'b0;
			seg_idx <= 16'h0000;
			seg_sub <= 8'h00;
			seg_off <= 16'h0000;
			seg_total <= 16'h0000;
			resp_cmd <= 8'h00;
			resp_data <= 56'h0;
		end else begin
			case (state)
			sph_pkg::SPH_IDLE: begin
				if (sdo_q.valid) begin
					od_index <= f_idx;
					od_sub <= f_sub;
					od_wdata <= f_val;
					od_wlen <= 3'(sph_pkg::EXP_MAX_LEN) - {1'b0, f_cmd[sph_pkg::LEN_POS +: 2]}; // RULE4
					od_offset <= 16'h0000;
					od_write <= f_wr;
					acc_seg <= 1'b0;
					if (f_len != sph_pkg::SDO_FRAME_LEN) begin
						resp_cmd <= sph_pkg::CMD_ERR; // RULE23
						resp_data <= {ABORT_CODE, f_sub, f_idx};
						seg_active <= 1'b0;
						state <= sph_pkg::SPH_SEND;
					end else if (f_wr && f_tt) begin
						resp_cmd <= sph_pkg::CMD_WR_ACK; // RULE8
						resp_data <= {32'h0000_0000, f_sub, f_idx};
						seg_active <= 1'b0;
						state <= sph_pkg::SPH_SEND;
					end else if (f_rd && f_tt) begin
						resp_cmd <= sph_pkg::CMD_RD_BASE | {4'h0, 2'h3, 2'h0}; // RULE11
						resp_data <= {24'h000000, f_tt_val, f_sub, f_idx};
						seg_active <= 1'b0;
						state <= sph_pkg::SPH_SEND;
					end else if (f_wr || f_rd) begin
						od_req <= 1'b1; // RULE6
						seg_active <= 1'b0;
						state <= sph_pkg::SPH_ACCESS;
					end else if (f_seg && seg_active && f_tog == seg_tog) begin
						od_req <= 1'b1; // RULE14
						od_write <= 1'b0;
						od_index <= seg_idx;
						od_sub <= seg_sub;
						od_offset <= seg_off;
						acc_seg <= 1'b1;
						state <= sph_pkg::SPH_ACCESS;
					end else begin
						resp_cmd <= sph_pkg::CMD_ERR; // RULE9
						resp_data <= {ABORT_CODE, f_sub, f_idx};
						seg_active <= 1'b0;
						state <= sph_pkg::SPH_SEND;
					end
				end
			end
			sph_pkg::SPH_ACCESS: begin
				if (od_ack) begin
					od_req <= 1'b0;
					state <= sph_pkg::SPH_SEND;
					if (od_err || (!od_write && !acc_seg && od_rlen == 16'h0000)) begin
						resp_cmd <= sph_pkg::CMD_ERR; // RULE9
						resp_data <= {ABORT_CODE, od_sub, od_index};
						seg_active <= 1'b0;
					end else if (od_write) begin
						resp_cmd <= sph_pkg::CMD_WR_ACK; // RULE8
						resp_data <= {32'h0000_0000, od_sub, od_index};
					end else if (acc_seg) begin
						resp_cmd <= seg_cmd; // RULE16
						resp_data <= od_rdata; // RULE2
						seg_off <= seg_off + sph_pkg::SEG_BYTES;
						seg_tog <= ~seg_tog; // RULE14
						seg_active <= !seg_last; // RULE15
					end else if (od_rlen > sph_pkg::EXP_MAX_LEN) begin
						resp_cmd <= sph_pkg::CMD_RD_LONG; // RULE13
						resp_data <= {16'h0000, od_rlen, od_sub, od_index}; // RULE5
						seg_active <= 1'b1;
						seg_tog <= 1'b0;
						seg_idx <= od_index;
						seg_sub <= od_sub;
						seg_off <= 16'h0000;
						seg_total <= od_rlen;
					end else begin
						resp_cmd <= sph_pkg::CMD_RD_BASE | {4'h0, rd_code, 2'h0}; // RULE11
						resp_data <= {od_rdata[31:0], od_sub, od_index}; // RULE1
					end
				end
			end
			sph_pkg::SPH_SEND: begin
				if (sdo_sent) begin
					state <= sph_pkg::SPH_IDLE; // RULE25
				end
			end
			default: begin
				state <= sph_pkg::SPH_IDLE;
			end
			endcase
		end
	end
endmodule

// File: tb/sph_od_model.sv
// object dictionary stand-in answering the handler's access requests
`timescale 1ns/1ps
module sph_od_model (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// requests
	input wire logic od_req,
	input wire logic od_write,
	input wire logic [15:0] od_index,
	input wire logic [7:0] od_sub,
	input wire logic [15:0] od_offset,
	input wire logic [31:0] od_wdata,
	input wire logic [2:0] od_wlen,
	// answers
	output logic od_ack,
	output logic od_err,
	output logic [55:0] od_rdata,
	output logic [15:0] od_rlen,
	// last write seen
	output logic [31:0] last_wdata,
	output logic [2:0] last_wlen
);
	logic slow;
	logic [3:0] wait_cnt;
	logic [55:0] seg;
	// answers alternate between prompt and slow
	always_ff @(posedge clock) begin
		od_ack <= 1'b0;
		if (reset) begin
			slow <= 1'b0;
			wait_cnt <= 4'h0;
		end else if (od_req && !od_ack) begin
			wait_cnt <= wait_cnt + 4'h1;
			if (wait_cnt == (slow ? 4'h6 : 4'h1)) begin
				od_ack <= 1'b1;
				wait_cnt <= 4'h0;
				slow <= !slow;
			end
		end
	end
	always_ff @(posedge clock) begin
		if (od_ack && od_write) begin
			last_wdata <= od_wdata;
			last_wlen <= od_wlen;
		end
	end
	// byte k of an object is its offset plus k
	always_comb begin
		for (int k = 0; k < 7; k++) seg[8*k +: 8] = od_offset[7:0] + 8'(k);
	end
	// outside an answer the lines carry junk, never the last value
	assign od_rdata = od_ack ? seg : ~seg;
	assign od_rlen = od_ack ? {12'h000, od_index[3:0]} : 16'hFFFF;
	assign od_err = od_ack ? od_sub == 8'hEE : 1'b1;
endmodule

// File: tb/sph_message_handler_chk.sv
// port assertions of the message handler
`timescale 1ns/1ps
module sph_message_handler_chk (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// watched ports
	input wire logic [6:0] node_id,
	input wire logic node_id_valid,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [10:0] tx_cob,
	input wire logic [3:0] tx_len,
	input wire logic [63:0] tx_data,
	input wire logic od_req,
	input wire logic od_ack,
	input wire logic od_err,
	input wire logic [15:0] od_index,
	input wire logic [7:0] od_sub,
	input wire logic rpdo_apply,
	input wire logic [3:0] rpdo_len
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	wire logic sdo_tx = tx_valid && tx_cob[10:7] == sph_pkg::FC_SDO_TX;
	sequence s_answer;
		sdo_tx;
	endsequence
	sequence s_error;
		sdo_tx && tx_data[7:0] == sph_pkg::CMD_ERR;
	endsequence
	a_tx_holds: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_cob))
		else $error("tx frame changed before taken");
	a_od_holds: assert property (
		od_req && !od_ack |=> od_req && $stable(od_index) && $stable(od_sub))
		else $error("dictionary request changed early");
	a_sdo_eight: assert property (sdo_tx |-> tx_len == sph_pkg::SDO_FRAME_LEN)
		else $error("service frame not eight bytes");
	a_ack_empty: assert property (sdo_tx && tx_data[7:0] == 8'h60 |-> tx_data[63:32] == 32'h0)
		else $error("write answer carries data");
	a_read_codes: assert property (
		sdo_tx && tx_data[7:4] == 4'h4
		|-> tx_data[7:0] inside {8'h41, 8'h43, 8'h47, 8'h4B, 8'h4F})
		else $error("bad read answer command");
	a_answer_due: assert property (od_ack && !od_err |-> ##[1:40] s_answer)
		else $error("no answer after access");
	a_err_answer: assert property (od_ack && od_err |-> ##[1:40] s_error)
		else $error("no error answer after failed access");
	a_node_valid: assert property (
		!$past(reset) && !$past(reset, 2) |-> node_id_valid == ($past(node_id, 2) != 7'h00))
		else $error("node id valid wrong");
	a_rpdo_len: assert property (
		rpdo_apply |-> rpdo_len != 4'h0 && rpdo_len <= sph_pkg::PDO_MAX_LEN)
		else $error("applied process data length out of range");
endmodule

// File: tb/test_sph_message_handler.sv
// self-checking bench of the message handler
`timescale 1ns/1ps
module test_sph_message_handler;
	logic clock, reset, rx_valid, rx_ready, tx_valid, tx_ready, od_req, od_write, od_ack, od_err;
	logic node_id_valid, rpdo_apply, tpdo_valid, tpdo_ready, full;
	logic [6:0] node_id;
	logic [10:0] rx_cob, tx_cob, s_cob;
	logic [3:0] rx_len, tx_len, rpdo_len, tpdo_len, s_len;
	logic [63:0] rx_data, tx_data, rpdo_data, tpdo_data, seen;
	logic [15:0] od_index, od_offset, od_rlen;
	logic [7:0] od_sub;
	logic [31:0] od_wdata, last_wdata;
	logic [2:0] od_wlen, last_wlen;
	logic [55:0] od_rdata;
	logic [1:0] rpdo_num, tpdo_num;
	int errors, cmp_count, n;
	typedef struct packed {
		logic [7:0] cmd;
		logic [15:0] idx;
		logic [7:0] sub;
		logic [7:0] ecmd;
		logic [31:0] eval;
	} sph_row_t;
	sph_row_t rows [15] = '{
		'{8'h23, 16'h2000, 8'h01, 8'h60, 32'h0}, '{8'h27, 16'h2000, 8'h01, 8'h60, 32'h0},
		'{8'h2B, 16'h2000, 8'h01, 8'h60, 32'h0}, '{8'h2F, 16'h2000, 8'h01, 8'h60, 32'h0},
		'{8'h40, 16'h3001, 8'h00, 8'h4F, 32'h0}, '{8'h40, 16'h3002, 8'h00, 8'h4B, 32'h0100},
		'{8'h40, 16'h3003, 8'h00, 8'h47, 32'h020100}, '{8'h40, 16'h3004, 8'h00, 8'h43, 32'h03020100},
		'{8'h40, 16'h3004, 8'hEE, 8'h80, 32'h0}, '{8'h40, 16'h3000, 8'h00, 8'h80, 32'h0},
		'{8'h99, 16'h2000, 8'h01, 8'h80, 32'h0}, '{8'h2F, 16'h1800, 8'h02, 8'h60, 32'h0},
		'{8'h2F, 16'h1401, 8'h02, 8'h60, 32'h0}, '{8'h40, 16'h1401, 8'h02, 8'h4F, 32'h44},
		'{8'h40, 16'h300A, 8'h00, 8'h41, 32'h000A}};
	sph_message_handler sph_message_handler_i (.clock, .reset, .node_id, .node_id_valid,
		.rx_valid, .rx_ready, .rx_cob, .rx_len, .rx_data, .tx_valid, .tx_ready, .tx_cob,
		.tx_len, .tx_data, .od_req, .od_write, .od_index, .od_sub, .od_offset, .od_wdata,
		.od_wlen, .od_ack, .od_err, .od_rdata, .od_rlen, .rpdo_apply, .rpdo_num, .rpdo_len,
		.rpdo_data, .tpdo_valid, .tpdo_ready, .tpdo_num, .tpdo_len, .tpdo_data);
	sph_od_model sph_od_model_i (.clock, .reset, .od_req, .od_write, .od_index, .od_sub,
		.od_offset, .od_wdata, .od_wlen, .od_ack, .od_err, .od_rdata, .od_rlen, .last_wdata,
		.last_wlen);
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic hang(input string what);
		errors++;
		$display("[FAIL] %s expected response seen timeout", what);
		report_and_stop();
	endtask
	// bytes past the valid length are not compared
	function automatic logic [31:0] mask(input logic [7:0] c);
		if (c == 8'h41) return 32'h0000FFFF;
		if (c[7:4] == 4'h4 || c[7:4] == 4'h2) return 32'hFFFFFFFF >> (8 * c[3:2]);
		return 32'hFFFFFFFF;
	endfunction
	task automatic send(input logic [10:0] cob, input logic [3:0] len, input logic [63:0] d);
		int k;
		rx_valid <= 1'b1;
		rx_cob <= cob;
		rx_len <= len;
		rx_data <= d;
		k = 0;
		@(negedge clock);
		while (rx_ready !== 1'b1) begin
			if (++k > 60) hang("rx take");
			@(negedge clock);
		end
		@(posedge clock);
		rx_valid <= 1'b0;
		@(posedge clock);
	endtask
	task automatic get_tx;
		int k;
		k = 0;
		@(negedge clock);
		while (tx_valid !== 1'b1) begin
			if (++k > 80) hang("tx frame");
			@(negedge clock);
		end
		seen = tx_data;
		s_cob = tx_cob;
		s_len = tx_len;
		@(posedge clock);
	endtask
	task automatic sdo(input logic [7:0] c, input logic [15:0] i, input logic [7:0] s);
		send(11'h605, 4'h8, {32'h11223344, s, i, c});
		get_tx();
		chk("answer id", 64'(s_cob), 64'h585);
	endtask
	task automatic get_apply;
		int k;
		k = 0;
		@(negedge clock);
		while (rpdo_apply !== 1'b1) begin
			if (++k > 6) hang("apply");
			@(negedge clock);
		end
		seen = rpdo_data;
		s_len = rpdo_len;
		s_cob = 11'(rpdo_num);
		@(posedge clock);
	endtask
	task automatic quiet(input string what);
		logic [31:0] h;
		h = 32'h0;
		repeat (8) begin
			@(negedge clock);
			h += 32'(tx_valid) + 32'(rpdo_apply);
		end
		chk(what, 64'(h), 64'h0);
		@(posedge clock);
	endtask
	initial begin
		errors = 0;
		cmp_count = 0;
		reset = 1'b1;
		node_id = 7'h05;
		{rx_valid, rx_cob, rx_len, rx_data, tpdo_valid, tpdo_num, tpdo_len, tpdo_data} = '0;
		tx_ready = 1'b1;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		chk("reset outputs", 64'({rx_ready, tpdo_ready, tx_valid, od_req}), 64'hC);
		repeat (3) @(posedge clock);
		chk("node valid", 64'(node_id_valid), 64'h1);
		$display("test reset done");
		for (int i = 0; i < 15; i++) begin
			sdo(rows[i].cmd, rows[i].idx, rows[i].sub);
			chk("command", 64'(rows[i].ecmd), 64'(seen[7:0]));
			chk("echo", 64'({rows[i].sub, rows[i].idx}), 64'(seen[31:8]));
			chk("data", 64'(rows[i].eval), 64'(seen[63:32] & mask(rows[i].ecmd)));
			if (rows[i].idx == 16'h2000 && rows[i].ecmd == 8'h60) begin
				chk("wdata", 64'(32'h11223344 & mask(rows[i].cmd)), 64'(last_wdata & mask(rows[i].cmd)));
				chk("wlen", 64'(3'h4 - rows[i].cmd[3:2]), 64'(last_wlen));
			end
		end
		$display("test table done");
		sdo(8'h60, 16'h300A, 8'h00);
		chk("segment 0", seen, 64'h06050403020100_00);
		sdo(8'h70, 16'h300A, 8'h00);
		chk("segment last", 64'(seen[31:0]), 64'h09080719);
		sdo(8'h70, 16'h300A, 8'h00);
		chk("stray segment", 64'(seen[7:0]), 64'h80);
		send(11'h605, 4'h7, {32'h0, 8'h00, 16'h3004, 8'h40});
		get_tx();
		chk("short frame", 64'(seen[7:0]), 64'h80);
		$display("test segments done");
		send(11'h205, 4'h2, 64'hFFFF_FFFF_FFFF_BEEF);
		get_apply();
		chk("event rpdo", 64'hBEEF, seen);
		chk("event rpdo num len", 64'h02, 64'({s_cob[1:0], s_len}));
		send(11'h305, 4'h1, 64'h77);
		quiet("sync rpdo early");
		send(11'h080, 4'h0, 64'h0);
		get_apply();
		chk("sync rpdo", {s_cob[1:0], seen}, {2'h1, 64'h77});
		$display("test receive pdo done");
		for (int p = 1; p >= 0; p--) begin
			tpdo_valid <= 1'b1;
			tpdo_num <= 2'(p);
			tpdo_len <= 4'h3;
			tpdo_data <= 64'hAAAA_AAAA_AA12_3456;
			@(negedge clock);
			chk("tpdo ready", 64'(tpdo_ready), 64'h1);
			@(posedge clock);
			tpdo_valid <= 1'b0;
			if (p == 0) begin
				quiet("sync tpdo early");
				send(11'h080, 4'h0, 64'h0);
			end
			get_tx();
			chk("tpdo frame", 64'h123456, seen);
			chk("tpdo id len", 64'({11'h185 + 11'(p * 256), 4'h3}), 64'({s_cob, s_len}));
		end
		$display("test transmit pdo done");
		tx_ready <= 1'b0;
		rx_valid <= 1'b1;
		rx_cob <= 11'h605;
		rx_len <= 4'h8;
		rx_data <= {32'h0, 8'h00, 16'h3001, 8'h40};
		n = 0;
		full = 1'b0;
		repeat (16) begin
			@(negedge clock);
			if (rx_ready === 1'b1) n++;
			else full = 1'b1;
			@(posedge clock);
		end
		rx_valid <= 1'b0;
		tx_ready <= 1'b1;
		chk("queue refused", 64'(full), 64'h1);
		repeat (n) begin
			get_tx();
			chk("queued answer", 64'(seen[7:0]), 64'h4F);
		end
		quiet("no extra answer");
		$display("test queue done");
		report_and_stop();
	end
endmodule
bind sph_message_handler sph_message_handler_chk sph_message_handler_chk_i (.clock, .reset,
	.node_id, .node_id_valid, .tx_valid, .tx_ready, .tx_cob, .tx_len, .tx_data, .od_req,
	.od_ack, .od_err, .od_index, .od_sub, .rpdo_apply, .rpdo_len);
